// File: cfg_decode_consts.svh
`ifndef CFG_DECODE_CONSTS_SVH
`define CFG_DECODE_CONSTS_SVH

// Register byte offsets on the APB bus
`define CFG_ADDR_W          8
`define CFG_WORD_OFS        8'h00
`define CFG_CTRL_OFS        8'h04
`define CFG_STATUS_OFS      8'h08

// Configuration word layout
`define CFG_WORD_W          14
`define CFG_BLANK_WORD      14'h3FFF
`define CFG_UNIMPL_MASK     14'h3104
`define CFG_CLOCK_OUTPUT_PIN_BIT      11
`define CFG_BOR_HI          10
`define CFG_BOR_LO          9
`define CFG_CP_BIT          7
`define CFG_RSTPIN_BIT      6
`define CFG_POWERUP_TIMER_BIT        5
`define CFG_WDT_HI          4
`define CFG_WDT_LO          3
`define CFG_OSC_HI          1
`define CFG_OSC_LO          0

// Control register fields
`define CTRL_SBOR_BIT       0
`define CTRL_SWDT_BIT       1
`define CTRL_ERASE_BIT      2
`define CTRL_SBOR_RST       1'b0
`define CTRL_SWDT_RST       1'b0

// Status register fields
`define STAT_BOR_BIT        0
`define STAT_WDT_BIT        1
`define STAT_POWERUP_TIMER_BIT       2
`define STAT_CLOCK_OUTPUT_PIN_BIT     3
`define STAT_RSTPIN_BIT     4
`define STAT_EXTCLK_BIT     5
`define STAT_CP_BIT         6
`define STAT_LOADED_BIT     7
`define STAT_OSC_LO         8
`define STAT_WORD_LO        16

`endif

// File: cfg_decode_pkg.sv
package cfg_decode_pkg;

    // Shared encoding of the brown-out and watchdog mode fields
    typedef enum logic [1:0] {
        EN_OFF = 2'h0,
        EN_SW  = 2'h1,
        EN_RUN = 2'h2,
        EN_ON  = 2'h3
    } en_mode_t;

    typedef enum logic [1:0] {
        OSC_INTERNAL = 2'h0,
        OSC_EXT_LOW  = 2'h1,
        OSC_EXT_MED  = 2'h2,
        OSC_EXT_HIGH = 2'h3
    } osc_mode_t;

endpackage

// File: mode_gate.sv
`timescale 1ns/1ps
`default_nettype none

module mode_gate (
    input  wire logic [1:0] mode_i,
    input  wire logic       sleep_i,
    input  wire logic       sw_en_i,
    output logic            en_o
);

    always_comb begin
        case (cfg_decode_pkg::en_mode_t'(mode_i))
            cfg_decode_pkg::EN_ON:  en_o = 1'b1;
            cfg_decode_pkg::EN_RUN: en_o = ~sleep_i;
            cfg_decode_pkg::EN_SW:  en_o = sw_en_i;
            default:                en_o = 1'b0;
        endcase
    end

endmodule

`default_nettype wire

// File: config_word_decode.sv
// Contract
// RULE_01: Bits 13, 12, 8, 2 always read one
// RULE_02: Clock output enable zero drives clock out
// RULE_03: Brown-out mode 11: always on
// RULE_04: Brown-out mode 10: on unless sleeping
// RULE_05: Brown-out mode 01: software bit decides
// RULE_06: Brown-out mode 00: always off
// RULE_07: Code protect zero blocks external access
// RULE_08: Code protection cleared only by bulk erase
// RULE_09: Low-voltage programming forces reset pin, pull-up
// RULE_10: Otherwise reset pin select bit chooses function
// RULE_11: Power-up timer enable bit is active low
// RULE_12: Brown-out never implies power-up timer
// RULE_13: Watchdog mode 11: always on
// RULE_14: Watchdog mode 10: on unless sleeping
// RULE_15: Watchdog mode 01: software bit decides
// RULE_16: Watchdog mode 00: always off
// RULE_17: Oscillator field selects external or internal
// RULE_18: Oscillator choice fixed from power-up
// RULE_19: External modes take logic-level input clock
// RULE_20: Blank or erased word reads all ones
// RULE_21: Settings captured at reset, then held
`timescale 1ns/1ps
`default_nettype none
`include "cfg_decode_consts.svh"

module config_word_decode (
    // Clock and reset
    input  wire logic                    sys_clk_i,
    input  wire logic                    rstn_i,
    // APB slave
    input  wire logic                    psel_i,
    input  wire logic                    penable_i,
    input  wire logic                    pwrite_i,
    input  wire logic [`CFG_ADDR_W-1:0]  paddr_i,
    input  wire logic [31:0]             pwdata_i,
    output logic                         pready_o,
    output logic [31:0]                  prdata_o,
    output logic                         pslverr_o,
    // Core state
    input  wire logic                    sleep_i,
    input  wire logic                    low_voltage_programming_i,
    input  wire logic                    pin_pullup_enable_i,
    // Decoded settings
    output logic                         clock_output_drive_o,
    output logic                         brownout_reset_en_o,
    output logic                         watchdog_en_o,
    output logic                         powerup_timer_en_o,
    output logic                         external_reset_input_en_o,
    output logic                         reset_pin_pullup_o,
    output logic                         prog_mem_ext_access_o,
    output logic                         ext_clock_sel_o,
    output logic                         clock_input_pin_io_o,
    output logic [1:0]                   osc_mode_o
);

    logic [`CFG_WORD_W-1:0] nv_word_reg = `CFG_BLANK_WORD;
    logic [`CFG_WORD_W-1:0] nv_word_next;
    logic [`CFG_WORD_W-1:0] active_word_reg;
    logic                   capture_pending_reg;
    logic                   software_brownout_enable_reg;
    logic                   software_watchdog_enable_reg;
    logic                   ready_reg;
    logic [31:0]            rdata_reg;
    logic                   slverr_reg;
    logic [31:0]            rdata_next;
    logic                   hit_word;
    logic                   hit_ctrl;
    logic                   hit_stat;
    logic                   setup;
    logic                   wr_commit;
    logic                   erase_pulse;
    logic                   bor_en;
    logic                   wdt_en;
    logic [31:0]            status_word;

    // APB decoding
    assign setup     = psel_i & ~penable_i;
    assign wr_commit = psel_i & penable_i & ready_reg & pwrite_i;
    assign hit_word  = (paddr_i == `CFG_WORD_OFS);
    assign hit_ctrl  = (paddr_i == `CFG_CTRL_OFS);
    assign hit_stat  = (paddr_i == `CFG_STATUS_OFS);
    assign erase_pulse = wr_commit & hit_ctrl & pwdata_i[`CTRL_ERASE_BIT];

    // Programming the word; a plain write cannot lift protection
    always_comb begin
        nv_word_next = nv_word_reg;
        if (erase_pulse) begin
            // RULE_20: erase restores blank
            nv_word_next = `CFG_BLANK_WORD;
        end else if (wr_commit && hit_word) begin
            // RULE_01: unused bits stay one
            nv_word_next = pwdata_i[`CFG_WORD_W-1:0] | `CFG_UNIMPL_MASK;
            // RULE_08: protection is sticky
            nv_word_next[`CFG_CP_BIT] = pwdata_i[`CFG_CP_BIT] & nv_word_reg[`CFG_CP_BIT];
        end
    end

    // Nonvolatile cells start blank and survive reset,
    // otherwise a programmed word could never become active
    always_ff @(posedge sys_clk_i) begin
        nv_word_reg <= nv_word_next;
    end

    // RULE_21: one capture after reset release
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            capture_pending_reg <= 1'b1;
            active_word_reg     <= `CFG_BLANK_WORD;
        end else if (capture_pending_reg) begin
            capture_pending_reg <= 1'b0;
            active_word_reg     <= nv_word_reg;
        end
    end

    // Software enables, only heeded in their software modes
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            software_brownout_enable_reg <= `CTRL_SBOR_RST;
            software_watchdog_enable_reg <= `CTRL_SWDT_RST;
        end else if (wr_commit && hit_ctrl) begin
            software_brownout_enable_reg <= pwdata_i[`CTRL_SBOR_BIT];
            software_watchdog_enable_reg <= pwdata_i[`CTRL_SWDT_BIT];
        end
    end

    // RULE_03: brown-out mode decode
    // RULE_04: sleep stops run mode
    // RULE_06: mode 00 off
    mode_gate u_bor_gate (
        .mode_i  (active_word_reg[`CFG_BOR_HI:`CFG_BOR_LO]),
        .sleep_i (sleep_i),
        .sw_en_i (software_brownout_enable_reg),
        .en_o    (bor_en)
    );

    // RULE_13: watchdog mode decode
    // RULE_14: sleep stops run mode
    // RULE_15: software bit mode
    // RULE_16: mode 00 off
    mode_gate u_wdt_gate (
        .mode_i  (active_word_reg[`CFG_WDT_HI:`CFG_WDT_LO]),
        .sleep_i (sleep_i),
        .sw_en_i (software_watchdog_enable_reg),
        .en_o    (wdt_en)
    );

    // Decoded outputs, all registered
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            brownout_reset_en_o <= 1'b0;
            watchdog_en_o       <= 1'b0;
        end else begin
            // RULE_05: software-gated modes
            brownout_reset_en_o <= bor_en;
            watchdog_en_o       <= wdt_en;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            clock_output_drive_o  <= 1'b0;
            powerup_timer_en_o    <= 1'b0;
            prog_mem_ext_access_o <= 1'b0;
        end else begin
            // RULE_02: zero drives clock out
            clock_output_drive_o  <= ~active_word_reg[`CFG_CLOCK_OUTPUT_PIN_BIT];
            // RULE_11: active-low timer enable
            // RULE_12: no brown-out term here
            powerup_timer_en_o    <= ~active_word_reg[`CFG_POWERUP_TIMER_BIT];
            // RULE_07: protection blocks access
            prog_mem_ext_access_o <= active_word_reg[`CFG_CP_BIT];
        end
    end

    // Reset pin function; stays a reset input until capture
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            external_reset_input_en_o <= 1'b1;
            reset_pin_pullup_o        <= 1'b1;
        end else if (low_voltage_programming_i) begin
            // RULE_09: select bit ignored
            external_reset_input_en_o <= 1'b1;
            reset_pin_pullup_o        <= 1'b1;
        end else begin
            // RULE_10: select bit chooses
            external_reset_input_en_o <= active_word_reg[`CFG_RSTPIN_BIT];
            reset_pin_pullup_o        <= active_word_reg[`CFG_RSTPIN_BIT] |
                                         pin_pullup_enable_i;
        end
    end

    // Clock source follows the captured word only
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            osc_mode_o           <= 2'h3;
            ext_clock_sel_o      <= 1'b1;
            clock_input_pin_io_o <= 1'b0;
        end else begin
            // RULE_17: oscillator field decode
            // RULE_18: fixed after capture
            osc_mode_o           <= active_word_reg[`CFG_OSC_HI:`CFG_OSC_LO];
            // RULE_19: external logic-level clock
            ext_clock_sel_o      <= (active_word_reg[`CFG_OSC_HI:`CFG_OSC_LO] != 2'h0);
            clock_input_pin_io_o <= (active_word_reg[`CFG_OSC_HI:`CFG_OSC_LO] == 2'h0);
        end
    end

    // Status image of what downstream logic actually sees
    always_comb begin
        status_word = 32'h0000_0000;
        status_word[`STAT_BOR_BIT]    = brownout_reset_en_o;
        status_word[`STAT_WDT_BIT]    = watchdog_en_o;
        status_word[`STAT_POWERUP_TIMER_BIT]   = powerup_timer_en_o;
        status_word[`STAT_CLOCK_OUTPUT_PIN_BIT] = clock_output_drive_o;
        status_word[`STAT_RSTPIN_BIT] = external_reset_input_en_o;
        status_word[`STAT_EXTCLK_BIT] = ext_clock_sel_o;
        status_word[`STAT_CP_BIT]     = ~prog_mem_ext_access_o;
        status_word[`STAT_LOADED_BIT] = ~capture_pending_reg;
        status_word[`STAT_OSC_LO+:2]  = osc_mode_o;
        status_word[`STAT_WORD_LO+:`CFG_WORD_W] = active_word_reg;
    end

    always_comb begin
        rdata_next = 32'h0000_0000;
        if (hit_word) begin
            // RULE_01: unused bits read one
            rdata_next[`CFG_WORD_W-1:0] = nv_word_reg | `CFG_UNIMPL_MASK;
        end else if (hit_ctrl) begin
            rdata_next[`CTRL_SBOR_BIT] = software_brownout_enable_reg;
            rdata_next[`CTRL_SWDT_BIT] = software_watchdog_enable_reg;
        end else if (hit_stat) begin
            rdata_next = status_word;
        end
    end

    // One wait-free access phase; answer prepared in setup
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ready_reg  <= 1'b0;
            rdata_reg  <= 32'h0000_0000;
            slverr_reg <= 1'b0;
        end else begin
            ready_reg  <= setup;
            if (setup) begin
                rdata_reg  <= pwrite_i ? 32'h0000_0000 : rdata_next;
                slverr_reg <= ~(hit_word | hit_ctrl | hit_stat) |
                              (pwrite_i & hit_stat);
            end
        end
    end

    assign pready_o  = ready_reg;
    assign prdata_o  = rdata_reg;
    assign pslverr_o = slverr_reg & ready_reg;

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rstn_i);

    unimpl_read_ones_a: assert property ( // RULE_01
        (pready_o && psel_i && penable_i && !pwrite_i && hit_word)
        |-> (prdata_o[13] && prdata_o[12] && prdata_o[8] && prdata_o[2]))
        else $error("unused config bits not read as one");

    clock_output_pin_drive_a: assert property ( // RULE_02
        (!capture_pending_reg && !$past(capture_pending_reg))
        |-> (clock_output_drive_o == !active_word_reg[`CFG_CLOCK_OUTPUT_PIN_BIT]))
        else $error("clock output drive mismatch");

    bor_always_on_a: assert property ( // RULE_03
        (rstn_i && active_word_reg[`CFG_BOR_HI:`CFG_BOR_LO] == 2'h3) |=> brownout_reset_en_o)
        else $error("brown-out not forced on");

    bor_sleep_off_a: assert property ( // RULE_04
        (active_word_reg[`CFG_BOR_HI:`CFG_BOR_LO] == 2'h2)
        |=> (brownout_reset_en_o == !$past(sleep_i)))
        else $error("brown-out not following sleep");

    bor_software_a: assert property ( // RULE_05
        (active_word_reg[`CFG_BOR_HI:`CFG_BOR_LO] == 2'h1)
        |=> (brownout_reset_en_o == $past(software_brownout_enable_reg)))
        else $error("brown-out not following software bit");

    bor_off_a: assert property ( // RULE_06
        (active_word_reg[`CFG_BOR_HI:`CFG_BOR_LO] == 2'h0) |=> !brownout_reset_en_o)
        else $error("brown-out on while disabled");

    protect_sticky_a: assert property ( // RULE_08
        (!nv_word_reg[`CFG_CP_BIT] && !erase_pulse) |=> !nv_word_reg[`CFG_CP_BIT])
        else $error("code protection lifted without erase");

    rstpin_lvp_a: assert property ( // RULE_09
        low_voltage_programming_i |=> (external_reset_input_en_o && reset_pin_pullup_o))
        else $error("reset pin not forced under low-voltage programming");

    powerup_timer_low_a: assert property ( // RULE_11
        (!capture_pending_reg && !$past(capture_pending_reg))
        |-> (powerup_timer_en_o == !active_word_reg[`CFG_POWERUP_TIMER_BIT]))
        else $error("power-up timer polarity wrong");

    wdt_modes_a: assert property ( // RULE_14
        (active_word_reg[`CFG_WDT_HI:`CFG_WDT_LO] == 2'h2)
        |=> (watchdog_en_o == !$past(sleep_i)))
        else $error("watchdog not following sleep");

    wdt_software_a: assert property ( // RULE_15
        (active_word_reg[`CFG_WDT_HI:`CFG_WDT_LO] == 2'h1)
        |=> (watchdog_en_o == $past(software_watchdog_enable_reg)))
        else $error("watchdog not following software bit");

    erase_blank_a: assert property ( // RULE_20
        erase_pulse |=> (nv_word_reg == `CFG_BLANK_WORD))
        else $error("erase did not blank the word");

    settings_held_a: assert property ( // RULE_21
        !capture_pending_reg |=> ($stable(active_word_reg) && !capture_pending_reg))
        else $error("captured settings changed");

    osc_select_a: assert property ( // RULE_17
        (!capture_pending_reg && !$past(capture_pending_reg))
        |-> ((osc_mode_o == active_word_reg[`CFG_OSC_HI:`CFG_OSC_LO]) &&
             (ext_clock_sel_o == (active_word_reg[`CFG_OSC_HI:`CFG_OSC_LO] != 2'h0))))
        else $error("clock source select mismatch");

    clock_pin_a: assert property ( // RULE_19
        (!capture_pending_reg && !$past(capture_pending_reg))
        |-> (clock_input_pin_io_o == (active_word_reg[`CFG_OSC_HI:`CFG_OSC_LO] == 2'h0)))
        else $error("clock input pin function mismatch");

    protect_access_a: assert property ( // RULE_07
        (!capture_pending_reg && !$past(capture_pending_reg))
        |-> (prog_mem_ext_access_o == active_word_reg[`CFG_CP_BIT]))
        else $error("program memory access mismatch");

    rstpin_select_a: assert property ( // RULE_10
        (!low_voltage_programming_i && !capture_pending_reg)
        |=> ((external_reset_input_en_o == active_word_reg[`CFG_RSTPIN_BIT]) &&
             (reset_pin_pullup_o == (active_word_reg[`CFG_RSTPIN_BIT] |
                                     $past(pin_pullup_enable_i)))))
        else $error("reset pin function mismatch");

    wdt_always_on_a: assert property ( // RULE_13
        (rstn_i && active_word_reg[`CFG_WDT_HI:`CFG_WDT_LO] == 2'h3) |=> watchdog_en_o)
        else $error("watchdog not forced on");

    wdt_off_a: assert property ( // RULE_16
        (active_word_reg[`CFG_WDT_HI:`CFG_WDT_LO] == 2'h0) |=> !watchdog_en_o)
        else $error("watchdog on while disabled");

endmodule

`default_nettype wire

// File: config_word_decode_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "cfg_decode_consts.svh"

module config_word_decode_tb;
    logic        sys_clk   = 1'b0;
    logic        rstn      = 1'b0;
    logic        psel      = 1'b0;
    logic        penable   = 1'b0;
    logic        pwrite    = 1'b0;
    logic [7:0]  paddr     = 8'h00;
    logic [31:0] pwdata    = 32'h0000_0000;
    logic        sleep     = 1'b0;
    logic        low_voltage_programming       = 1'b0;
    logic        pu        = 1'b0;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic [10:0] dec;
    logic [15:0] rnd       = 16'h773A;
    logic [31:0] rd;
    logic        er;
    logic [13:0] w;
    logic [2:0]  v;
    logic [1:0]  sw;
    int          err_total = 0;
    int          tests_run = 0;
    int          cycles    = 0;

    always #20 sys_clk = ~sys_clk;

    config_word_decode DUT (
        .sys_clk_i                 (sys_clk),
        .rstn_i                    (rstn),
        .psel_i                    (psel),
        .penable_i                 (penable),
        .pwrite_i                  (pwrite),
        .paddr_i                   (paddr),
        .pwdata_i                  (pwdata),
        .pready_o                  (pready),
        .prdata_o                  (prdata),
        .pslverr_o                 (pslverr),
        .sleep_i                   (sleep),
        .low_voltage_programming_i (low_voltage_programming),
        .pin_pullup_enable_i       (pu),
        .clock_output_drive_o      (dec[10]),
        .brownout_reset_en_o       (dec[9]),
        .watchdog_en_o             (dec[8]),
        .powerup_timer_en_o        (dec[7]),
        .external_reset_input_en_o (dec[6]),
        .reset_pin_pullup_o        (dec[5]),
        .prog_mem_ext_access_o     (dec[4]),
        .ext_clock_sel_o           (dec[3]),
        .clock_input_pin_io_o      (dec[2]),
        .osc_mode_o                (dec[1:0])
    );

    function automatic logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction

    function automatic logic gate(input logic [1:0] m, input logic s, input logic b);
        case (m)
            2'h3:    return 1'b1;
            2'h2:    return ~s;
            2'h1:    return b;
            default: return 1'b0;
        endcase
    endfunction

    function automatic logic [10:0] exp_dec(input logic [13:0] cw, input logic s,
                                            input logic [1:0] swb, input logic l,
                                            input logic p);
        logic ext;
        ext = l | cw[6];
        return {~cw[11], gate(cw[10:9], s, swb[0]), gate(cw[4:3], s, swb[1]), ~cw[5],
                ext, ext | p, cw[7], cw[1:0] != 2'h0, cw[1:0] == 2'h0, cw[1:0]};
    endfunction

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Holds the request until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        int n;
        n = 0;
        @(posedge sys_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        q = prdata;
        e = pslverr;
        chk("pready", 32'h1, {31'h0, pready});
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rst();
        rstn <= 1'b0;
        repeat (4) @(posedge sys_clk);
        rstn <= 1'b1;
        repeat (3) @(posedge sys_clk);
    endtask

    task automatic summarize();
        $display("checks %0d errors %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_total++;
            summarize();
        end
    end

    initial begin
        rst();
        chk("blank decode", {21'h0, exp_dec(14'h3FFF, 1'b0, 2'h0, 1'b0, 1'b0)}, {21'h0, dec});
        apb(1'b0, `CFG_WORD_OFS, 32'h0, rd, er);
        chk("blank word", 32'h0000_3FFF, rd);
        apb(1'b0, `CFG_CTRL_OFS, 32'h0, rd, er);
        chk("ctrl reset", 32'h0, rd);
        // Refused accesses: unmapped address and read-only status
        apb(1'b0, 8'h0C, 32'h0, rd, er);
        chk("unmapped err", 32'h1, {31'h0, er});
        apb(1'b1, `CFG_STATUS_OFS, 32'hFFFF_FFFF, rd, er);
        chk("status write err", 32'h1, {31'h0, er});
        for (int i = 0; i < 12; i++) begin
            rnd = lfsr(rnd);
            w = rnd[13:0];
            if (i < 4) begin
                w[10:9] = i[1:0];
                w[4:3]  = i[1:0];
                w[1:0]  = i[1:0];
            end
            apb(1'b1, `CFG_CTRL_OFS, 32'h4, rd, er);
            apb(1'b1, `CFG_WORD_OFS, {18'h0, w}, rd, er);
            apb(1'b0, `CFG_WORD_OFS, 32'h0, rd, er);
            w = w | `CFG_UNIMPL_MASK;
            chk("word readback", {18'h0, w}, rd);
            chk("word err", 32'h0, {31'h0, er});
            rst();
            apb(1'b0, `CFG_STATUS_OFS, 32'h0, rd, er);
            chk("active word", {18'h0, w}, {18'h0, rd[29:16]});
            // A new word must stay inactive until the next reset
            apb(1'b1, `CFG_WORD_OFS, {18'h0, ~w}, rd, er);
            for (int k = 0; k < 16; k++) begin
                rnd = lfsr(rnd);
                v   = (k < 8) ? k[2:0] : rnd[2:0];
                sw  = rnd[4:3];
                sleep <= v[0];
                low_voltage_programming   <= v[1];
                pu    <= v[2];
                apb(1'b1, `CFG_CTRL_OFS, {30'h0, sw}, rd, er);
                repeat (2) @(posedge sys_clk);
                chk("decode", {21'h0, exp_dec(w, v[0], sw, v[1], v[2])}, {21'h0, dec});
            end
        end
        apb(1'b1, `CFG_CTRL_OFS, 32'h4, rd, er);
        apb(1'b1, `CFG_WORD_OFS, 32'h0000_3F7F, rd, er);
        apb(1'b1, `CFG_WORD_OFS, 32'h0000_3FFF, rd, er);
        apb(1'b0, `CFG_WORD_OFS, 32'h0, rd, er);
        chk("protect sticky", 32'h0000_3F7F, rd);
        apb(1'b1, `CFG_CTRL_OFS, 32'h4, rd, er);
        apb(1'b0, `CFG_WORD_OFS, 32'h0, rd, er);
        chk("erased word", 32'h0000_3FFF, rd);
        summarize();
    end
endmodule

`default_nettype wire
